//--- logic/ct16_top.v
// Purpose: three cascadable 16-bit auto-reload timers behind an APB slave
// Assumes: divided clock enables come from logic on CLK_I; watchdog reset and sleep are pins
// Notes: one access cycle per transfer; read data is sampled in the setup cycle
//
// Added by the designer: the register offsets and the APB register port.

`include "ct16_map.vh"

// ************************************************************
// one timer channel
// ************************************************************
module ct16_timer (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // tick sources and power control
  input wire [7:0] div_en_i,
  input wire sleep_i,
  input wire cascade_i,
  // register writes
  input wire [31:0] wdata_i,
  input wire wr_ctrl_i,
  input wire wr_clkev_i,
  input wire wr_reload_i,
  // register contents
  output wire [7:0] ctrl_o,
  output wire [7:0] clkev_o,
  output wire [15:0] reload_o,
  output wire [15:0] count_o,
  // events
  output wire irq_o,
  output wire cascade_o,
  output wire clk_req_o
);
  reg [7:0] ctrl_reg;
  reg [7:0] clkev_reg;
  reg [15:0] reload_reg;
  reg [15:0] count_reg;
  reg pend_reg;
  reg casc_d_reg;
  reg halt_reg;
  reg os_run_reg;
  reg os_clr_reg;
  reg irq_reg;
  reg casc_out_reg;
  reg req_reg;
  reg [15:0] count_next;
  reg halt_next;

  wire enable = ctrl_reg[`CT16_CTRL_ENABLE];
  wire [1:0] mode = ctrl_reg[`CT16_CTRL_MODE_HI:`CT16_CTRL_MODE_LO];
  wire is_event = (mode == `CT16_MODE_EVENT);
  wire is_oneshot = (mode == `CT16_MODE_ONESHOT);
  wire reload_on_wrap = ctrl_reg[`CT16_CTRL_RELOAD_ON_WRAP];
  wire power_down_bit = ctrl_reg[`CT16_CTRL_POWER_DOWN];

  // selected divided enable is the timer clock
  wire tick_src = div_en_i[clkev_reg[`CT16_CLKEV_SEL_HI:0]];

  // edge detect on the cascade pulse from the previous channel
  wire edge_rise = cascade_i & ~casc_d_reg;
  wire edge_fall = ~cascade_i & casc_d_reg;
  wire evt = (clkev_reg[`CT16_CLKEV_RISE] & edge_rise) |
             (clkev_reg[`CT16_CLKEV_FALL] & edge_fall);
  wire tick = is_event ? evt : tick_src;

  wire low_power = power_down_bit | sleep_i;
  wire run = ((enable & ~is_oneshot) | os_run_reg) & ~halt_reg;
  wire step = run & tick;
  wire up = is_event & ctrl_reg[`CT16_CTRL_DIR_UP];
  wire wrap_up = step & up & (count_reg == `CT16_ALL_ONES);
  wire wrap_dn = step & ~up & (count_reg == `CT16_ZERO);
  wire wrap = wrap_up | wrap_dn;
  wire os_start = is_oneshot & enable & ~os_run_reg & ~halt_reg &
                  (~clkev_reg[`CT16_CLKEV_OS_EVT] | evt);
  wire use_reload = reload_on_wrap | pend_reg;

  // next counter value for one step
  always @* begin
    count_next = count_reg;
    if (up) begin
      if (count_reg == `CT16_ALL_ONES) begin
        count_next = use_reload ? reload_reg : `CT16_ZERO;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end else if (count_reg == `CT16_ZERO) begin
      // one-shot always rearms from reload and stops
      count_next = (use_reload | is_oneshot) ? reload_reg : `CT16_ALL_ONES;
    end else begin
      count_next = count_reg - 16'h0001;
    end
  end

  // in sleep or power-down, idle once a timer clock has passed or nothing is running
  always @* begin
    halt_next = halt_reg;
    if (!low_power) begin
      halt_next = 1'b0;
    end else if (tick_src | ~run) begin
      halt_next = 1'b1;
    end
  end

  // channel state
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `CT16_CTRL_DEFAULT;
      clkev_reg <= `CT16_CLKEV_DEFAULT;
      reload_reg <= `CT16_RELOAD_DEFAULT;
      count_reg <= `CT16_RELOAD_DEFAULT;
      pend_reg <= 1'b0;
      casc_d_reg <= 1'b0;
      halt_reg <= 1'b0;
      os_run_reg <= 1'b0;
      os_clr_reg <= 1'b0;
      irq_reg <= 1'b0;
      casc_out_reg <= 1'b0;
      req_reg <= 1'b1;
    end else begin
      casc_d_reg <= cascade_i;
      halt_reg <= halt_next;
      req_reg <= ~halt_next;
      // gated during sleep; while enable is clear only a running one-shot fires
      irq_reg <= wrap & ~halt_reg & (enable | os_run_reg);
      casc_out_reg <= wrap & ~halt_reg;
      // counting and wrap handling
      if (step) begin
        count_reg <= count_next;
        if (wrap_dn & pend_reg) begin
          pend_reg <= 1'b0;
        end
        if (wrap_dn & is_oneshot) begin
          os_run_reg <= 1'b0;
        end
      end
      if (halt_reg & ~low_power & (enable | os_run_reg)) begin
        count_reg <= reload_reg;
      end
      // one-shot start, then clear enable one tick later
      if (os_start) begin
        os_run_reg <= 1'b1;
        os_clr_reg <= 1'b1;
        count_reg <= reload_reg;
      end else if (os_clr_reg & tick_src) begin
        os_clr_reg <= 1'b0;
        ctrl_reg[`CT16_CTRL_ENABLE] <= 1'b0;
      end
      // software writes win over the hardware updates above
      if (wr_clkev_i) begin
        clkev_reg <= wdata_i[7:0];
      end
      if (wr_reload_i) begin
        reload_reg <= wdata_i[15:0];
        if (!run) begin
          count_reg <= wdata_i[15:0];
        end else begin
          pend_reg <= 1'b1;
        end
      end
      if (wr_ctrl_i) begin
        if (wdata_i[`CT16_CTRL_RESET]) begin
          ctrl_reg <= `CT16_CTRL_DEFAULT;
          clkev_reg <= `CT16_CLKEV_DEFAULT;
          count_reg <= reload_reg;
          pend_reg <= 1'b0;
          os_run_reg <= 1'b0;
          os_clr_reg <= 1'b0;
        end else begin
          ctrl_reg <= wdata_i[7:0] & 8'hFD; // reset bit self-clears
        end
      end
    end
  end

  assign ctrl_o = ctrl_reg;
  assign clkev_o = clkev_reg;
  assign reload_o = reload_reg;
  assign count_o = count_reg;
  assign irq_o = irq_reg;
  assign cascade_o = casc_out_reg;
  assign clk_req_o = req_reg;
endmodule // ct16_timer

// ************************************************************
// top: synchronisers, APB slave, three chained channels
// ************************************************************
module ct16_top (
  // clock and reset
  input wire CLK_I,
  input wire RESET_I,
  input wire WATCHDOG_RESET_N_I,
  // tick enables and sleep
  input wire [7:0] DIVIDED_CLOCK_ENABLES_I,
  input wire SLEEP_EN_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // per-channel outputs
  output wire [2:0] TIMER_IRQ_O,
  output wire [2:0] CASCADE_OUT_O,
  output wire [2:0] CORE_CLOCK_REQUEST_O
);
  reg wdt_s1_reg;
  reg wdt_s2_reg;
  reg slp_s1_reg;
  reg slp_s2_reg;
  reg [2:0] irq_src_reg;
  wire [23:0] ctrl_w;
  wire [23:0] clkev_w;
  wire [47:0] reload_w;
  wire [47:0] count_w;
  wire [2:0] irq_w;
  wire [2:0] casc_w;
  wire [2:0] req_w;
  wire [2:0] cin_w;

  // watchdog reset and sleep are pins: two flops before use
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      wdt_s1_reg <= 1'b1;
      wdt_s2_reg <= 1'b1;
      slp_s1_reg <= 1'b0;
      slp_s2_reg <= 1'b0;
    end else begin
      wdt_s1_reg <= WATCHDOG_RESET_N_I;
      wdt_s2_reg <= wdt_s1_reg;
      slp_s1_reg <= SLEEP_EN_I;
      slp_s2_reg <= slp_s1_reg;
    end
  end

  wire rst = RESET_I | ~wdt_s2_reg;

  // decode: channel windows at 0x00, 0x10, 0x20, source word at 0x30
  wire [1:0] sel_ch = PADDR_I[5:4];
  wire [1:0] sel_ofs = PADDR_I[3:2];
  wire in_ch = (PADDR_I[7:6] == 2'h0) & (sel_ch != 2'h3) & (PADDR_I[1:0] == 2'h0);
  wire is_src = (PADDR_I == `CT16_ADDR_IRQ_SRC);
  wire mapped = in_ch | is_src;
  wire setup = PSEL_I & ~PENABLE_I;
  // write lands only at the completing access edge
  wire acc_wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & mapped;

  // one wait-free access cycle after every setup cycle
  always @(posedge CLK_I) begin
    if (rst) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PREADY_O <= setup;
      PSLVERR_O <= setup & ~mapped;
      if (setup) begin
        PRDATA_O <= 32'h0000_0000;
        if (is_src) begin
          PRDATA_O <= {29'h0000_0000, irq_src_reg};
        end else if (in_ch & ~PWRITE_I) begin
          case (sel_ofs)
            `CT16_OFS_CTRL: PRDATA_O <= {24'h00_0000, ctrl_w[8*sel_ch +: 8]};
            `CT16_OFS_CLKEV: PRDATA_O <= {24'h00_0000, clkev_w[8*sel_ch +: 8]};
            `CT16_OFS_RELOAD: PRDATA_O <= {16'h0000, reload_w[16*sel_ch +: 16]};
            default: PRDATA_O <= {16'h0000, count_w[16*sel_ch +: 16]};
          endcase
        end
      end
    end
  end

  // sticky source bits, write one to clear; a new event beats the clear
  always @(posedge CLK_I) begin
    if (rst) begin
      irq_src_reg <= 3'h0;
    end else begin
      irq_src_reg <= (irq_src_reg & ~((acc_wr & is_src) ? PWDATA_I[2:0] : 3'h0)) | irq_w;
    end
  end

  // chain: channel 0 has no cascade source
  assign cin_w = {casc_w[1:0], 1'b0};

  genvar g;
  generate
    for (g = 0; g < `CT16_NUM_TIMERS; g = g + 1) begin : g_tmr
      wire hit = acc_wr & in_ch & (sel_ch == g);
      ct16_timer u_tmr (
        .clk_i(CLK_I),
        .rst_i(rst),
        .div_en_i(DIVIDED_CLOCK_ENABLES_I),
        .sleep_i(slp_s2_reg),
        .cascade_i(cin_w[g]),
        .wdata_i(PWDATA_I),
        .wr_ctrl_i(hit & (sel_ofs == `CT16_OFS_CTRL)),
        .wr_clkev_i(hit & (sel_ofs == `CT16_OFS_CLKEV)),
        .wr_reload_i(hit & (sel_ofs == `CT16_OFS_RELOAD)),
        .ctrl_o(ctrl_w[8*g +: 8]),
        .clkev_o(clkev_w[8*g +: 8]),
        .reload_o(reload_w[16*g +: 16]),
        .count_o(count_w[16*g +: 16]),
        .irq_o(irq_w[g]),
        .cascade_o(casc_w[g]),
        .clk_req_o(req_w[g])
      );
    end
  endgenerate

  assign TIMER_IRQ_O = irq_w;
  assign CASCADE_OUT_O = casc_w;
  assign CORE_CLOCK_REQUEST_O = req_w;
endmodule // ct16_top

//--- shared/ct16_map.vh
// Purpose: constants for the cascadable 16-bit timer block (three chained instances)
// Assumes: 50 MHz master clock, APB register access, 32-bit data, byte addresses
// Notes: each timer owns a 16-byte window; one shared interrupt source word follows
//
// How it works
// - timer 2 counts timer 1 wraps, timer 3 counts timer 2; timer 1 unchained
// - eight divided clock enables arrive; a select field picks the tick
// - low watchdog reset line returns all timers and registers to defaults
// - writing the reset bit of a control word resets that timer only
// - each overflow or underflow sets its own bit in the shared source word
// - no interrupt while the enable bit is clear, except from a running one-shot
// - power-down bit drops the core clock request once the timer is idle
// - sleep or power-down keeps the request at most one tick, then drops it
// - without power-down or sleep the request stays high, normal running
// - sleep gates counting and interrupts; wake restarts from the preload value
// - counting stops one tick after sleep is asserted
// - enable bit starts and stops counting in every mode but one-shot
// - timer mode always counts down on the selected internal tick
// - period follows from tick select and reload value
// - timer underflow loads reload when reload bit set, else wraps to all ones
// - interrupt fires on the underflow step past zero
// - count register reads the live counter
// - reload write while stopped goes straight into the counter
// - reload write while running lands at the next underflow
// - timer reset copies the reload value into the counter
// - event mode counts cascade input edges, direction from the direction bit
// - one-shot needs enable set to start; hardware clears enable one tick later
`ifndef CT16_MAP_VH
`define CT16_MAP_VH

// ************************************************************
// register map
// ************************************************************
`define CT16_OFS_CTRL 2'h0
`define CT16_OFS_CLKEV 2'h1
`define CT16_OFS_RELOAD 2'h2
`define CT16_OFS_COUNT 2'h3
`define CT16_ADDR_IRQ_SRC 8'h30
`define CT16_NUM_TIMERS 3

// ************************************************************
// control word fields
// ************************************************************
`define CT16_CTRL_ENABLE 0
`define CT16_CTRL_RESET 1
`define CT16_CTRL_MODE_LO 2
`define CT16_CTRL_MODE_HI 3
`define CT16_CTRL_DIR_UP 4
`define CT16_CTRL_RELOAD_ON_WRAP 5
`define CT16_CTRL_POWER_DOWN 6
`define CT16_CTRL_DEFAULT 8'h00
`define CT16_MODE_TIMER 2'h0
`define CT16_MODE_EVENT 2'h1
`define CT16_MODE_ONESHOT 2'h2

// ************************************************************
// clock and event word fields
// ************************************************************
`define CT16_CLKEV_SEL_HI 2
`define CT16_CLKEV_RISE 4
`define CT16_CLKEV_FALL 5
`define CT16_CLKEV_OS_EVT 6
`define CT16_CLKEV_DEFAULT 8'h00

// ************************************************************
// counter values
// ************************************************************
`define CT16_RELOAD_DEFAULT 16'hFFFF
`define CT16_ALL_ONES 16'hFFFF
`define CT16_ZERO 16'h0000

`endif

//--- testbench/ct16_apb_m.sv
// Purpose: apb master standing in for the controller cpu
// Assumes: one request at a time, go held for one cycle
// Notes: request held until pready; write data inverted once released
module ct16_apb_m (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request side
  input wire logic go_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic done_o = 1'b0,
  output logic [31:0] rdata_o = 32'h0,
  output logic err_o = 1'b0,
  // apb side
  output logic psel_o = 1'b0,
  output logic penable_o = 1'b0,
  output logic pwrite_o = 1'b0,
  output logic [7:0] paddr_o = 8'h00,
  output logic [31:0] pwdata_o = 32'h0,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // setup, then access until ready; data taken only at that edge
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      psel_o <= 1'b0;
      penable_o <= 1'b0;
    end else if (psel_o && penable_o && pready_i) begin
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o <= ~pwdata_o;
      rdata_o <= prdata_i;
      err_o <= pslverr_i;
      done_o <= 1'b1;
    end else if (psel_o) begin
      penable_o <= 1'b1;
    end else if (go_i) begin
      psel_o <= 1'b1;
      pwrite_o <= wr_i;
      paddr_o <= addr_i;
      pwdata_o <= wdata_i;
    end
  end
endmodule // ct16_apb_m

//--- testbench/ct16_chk_sva.sv
// Purpose: port checks of the three-timer block
// Assumes: one clock, sync reset; channel 0 stands for all three
// Notes: bound to ct16_top from tb_top
module ct16_chk (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic SLEEP_EN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [2:0] TIMER_IRQ_O,
  input wire logic [2:0] CASCADE_OUT_O,
  input wire logic [2:0] CORE_CLOCK_REQUEST_O
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // properties
  // ****************
  default clocking dck @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  // zero wait states, so ready follows setup at once
  ready_next_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("ready missing after setup");
  ready_access_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("ready outside access");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  unmapped_err_a: assert property (PSEL_I && !PENABLE_I && PADDR_I > 8'h33 |=> PSLVERR_O)
    else $error("unmapped access accepted");
  mapped_ok_a: assert property (PSEL_I && !PENABLE_I && PADDR_I < 8'h34 |=> !PSLVERR_O)
    else $error("mapped access refused");
  irq_wrap_a: assert property (TIMER_IRQ_O[0] |-> CASCADE_OUT_O[0])
    else $error("interrupt without wrap");
  cascade_pulse_a: assert property (CASCADE_OUT_O[0] |=> !CASCADE_OUT_O[0])
    else $error("cascade pulse too long");
  sleep_drop_a: assert property ($rose(SLEEP_EN_I) |->
    ##[1:200] (!CORE_CLOCK_REQUEST_O[0] || !SLEEP_EN_I)) else $error("request kept in sleep");
  halt_quiet_a: assert property (!CORE_CLOCK_REQUEST_O[0] &&
    !$past(CORE_CLOCK_REQUEST_O[0]) |-> !TIMER_IRQ_O[0]) else $error("interrupt while halted");
endmodule // ct16_chk

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the three-timer block
// Assumes: 50 MHz clock, tick enables made here from a free counter
// Notes: reads are compared with values worked out by hand
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} ct16_row_t;
  logic clk = 0, rst = 1, wd_n = 1, slp = 0, go = 0, wr = 0, done, err, psel, pen, pwr;
  logic prdy, perr;
  logic [7:0] en = 8'h00, ad = 8'h00, pad;
  logic [31:0] wd = 32'h0, rd, pwd, prd, s;
  logic [2:0] irq, cas, req;
  int errors = 0, checked = 0, dc = 0, nirq = 0;
  ct16_row_t rows [9] = '{'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h18, 32'h0, 32'hFFFF, 1'b0}, '{1'b0, 8'h2C, 32'h0, 32'hFFFF, 1'b0},
    '{1'b1, 8'h0C, 32'h1234, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'hFFFF, 1'b0},
    '{1'b0, 8'h30, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h34, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h40, 32'h1, 32'h0, 1'b1}};
  // ****************
  // clock, tick enables, devices
  // ****************
  always #10 clk = ~clk;
  // bit k high once every 2^k cycles
  always @(posedge clk) begin
    dc <= dc + 1;
    for (int k = 0; k < 8; k++) en[k] <= ((dc + 1) % (1 << k)) == 0;
    if (irq[0] === 1'b1) nirq <= nirq + 1;
  end
  ct16_apb_m u_mst (.clk_i(clk), .rst_i(rst), .go_i(go), .wr_i(wr), .addr_i(ad), .wdata_i(wd),
    .done_o(done), .rdata_o(rd), .err_o(err), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(pad), .pwdata_o(pwd), .prdata_i(prd), .pready_i(prdy), .pslverr_i(perr));
  ct16_top u_dut (.CLK_I(clk), .RESET_I(rst), .WATCHDOG_RESET_N_I(wd_n),
    .DIVIDED_CLOCK_ENABLES_I(en), .SLEEP_EN_I(slp), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pad), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
    .PSLVERR_O(perr), .TIMER_IRQ_O(irq), .CASCADE_OUT_O(cas), .CORE_CLOCK_REQUEST_O(req));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    checked++;
    if (v !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    go <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    go <= 1'b0;
    for (int n = 0; n < 20 && done !== 1'b1; n++) @(negedge clk);
    // a transfer that never completes is a failure, not a silent skip
    if (done !== 1'b1) errors++;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // returns one cycle after a channel 0 interrupt
  task automatic wirq;
    for (int n = 0; n < 8000 && irq[0] !== 1'b1; n++) @(negedge clk);
    if (irq[0] !== 1'b1) errors++;
    @(negedge clk);
  endtask
  task automatic gap(input int e);
    int n;
    wirq();
    n = 1;
    while (irq[0] !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(n, e);
  endtask
  task automatic summarize;
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].e);
      chk(err, rows[i].x);
    end
    bus(1'b1, 8'h08, 32'h2);
    rdc(8'h0C, 32'h2);
    bus(1'b1, 8'h04, 32'h3);
    bus(1'b1, 8'h00, 32'h21);
    gap(24);
    bus(1'b1, 8'h04, 32'h7);
    bus(1'b1, 8'h08, 32'h5);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd[15:0] < 16'h5, 1'b1);
    wirq();
    rdc(8'h0C, 32'h5);
    bus(1'b1, 8'h00, 32'h1);
    wirq();
    rdc(8'h0C, 32'hFFFF);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b0, 8'h0C, 32'h0);
    s = rd;
    repeat (300) @(posedge clk);
    rdc(8'h0C, s);
    chk(nirq, 4);
    rdc(8'h30, 32'h1);
    bus(1'b1, 8'h30, 32'h1);
    rdc(8'h30, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h08, 32'h9);
    bus(1'b1, 8'h00, 32'h2);
    rdc(8'h00, 32'h0);
    rdc(8'h0C, 32'h9);
    // channel 1 counts channel 0 wraps, both on the one master tick
    bus(1'b1, 8'h00, 32'h21);
    bus(1'b1, 8'h14, 32'h10);
    bus(1'b1, 8'h10, 32'h05);
    repeat (100) @(posedge clk);
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd[15:0] < 16'hFFFF, 1'b1);
    bus(1'b1, 8'h20, 32'h40);
    repeat (10) @(posedge clk);
    chk(req, 3'b011);
    bus(1'b1, 8'h08, 32'd100);
    bus(1'b1, 8'h04, 32'h6);
    wirq();
    repeat (400) @(posedge clk);
    slp <= 1'b1;
    repeat (200) @(posedge clk);
    chk(req, 3'b000);
    slp <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd[15:0] >= 16'd99, 1'b1);
    wd_n <= 1'b0;
    repeat (4) @(posedge clk);
    wd_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(8'h08, 32'hFFFF);
    rdc(8'h20, 32'h0);
    // one-shot on channel 2 at the fastest tick: start, self-clear, one interrupt
    bus(1'b1, 8'h28, 32'h3);
    bus(1'b1, 8'h20, 32'h9);
    rdc(8'h20, 32'h8);
    rdc(8'h30, 32'h4);
    summarize();
  end
  // hang guard, well beyond the expected run
  initial begin
    #400000;
    errors++;
    summarize();
  end
endmodule // tb_top
bind ct16_top ct16_chk u_chk (.CLK_I(CLK_I), .RESET_I(RESET_I), .SLEEP_EN_I(SLEEP_EN_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .TIMER_IRQ_O(TIMER_IRQ_O), .CASCADE_OUT_O(CASCADE_OUT_O),
  .CORE_CLOCK_REQUEST_O(CORE_CLOCK_REQUEST_O));
